// file: src/mpp_consts.vh
// Constants of the motion profile parameter set
// Assumes a 10 MHz mclk and parameter addresses as seen from the fieldbus
`ifndef MPP_CONSTS_VH
`define MPP_CONSTS_VH

// Parameter addresses (fieldbus register numbers)
`define MPP_ADDR_SPEED_CEILING 16'h0612
`define MPP_ADDR_PROFILE_ACC 16'h0614
`define MPP_ADDR_PROFILE_DEC 16'h0616
`define MPP_ADDR_JERK_TIME 16'h061a
`define MPP_ADDR_RAMP_SHAPE 16'h0626
`define MPP_ADDR_VEL_TARGET 16'h1b1a
`define MPP_ADDR_POS_TARGET 16'h1b1c
`define MPP_ADDR_PROFILE_SHAPE 16'h1b2a

// Reset values
`define MPP_RST_SPEED_CEILING 16'h3390
`define MPP_RST_PROFILE_ACC 32'h00000258
`define MPP_RST_PROFILE_DEC 32'h000002ee
`define MPP_RST_JERK_TIME 16'h0000
`define MPP_RST_RAMP_SHAPE 16'h0000
`define MPP_RST_VEL_TARGET 32'h00000000
`define MPP_RST_POS_TARGET 32'h00000000
`define MPP_RST_PROFILE_SHAPE 16'h0000

// Ranges
`define MPP_SPEED_CEILING_MIN 16'h003c
`define MPP_SPEED_CEILING_MAX 16'h3390
`define MPP_ACC_MIN 32'h00000001
`define MPP_DEC_MIN 32'h000000c8
`define MPP_ACCDEC_MAX 32'h002dc6c0
`define MPP_JERK_MAX 16'h0080
`define MPP_RAMP_MOTOR_OPT 16'hffff
`define MPP_RAMP_LINEAR 16'h0000
`define MPP_PROFILE_LINEAR 16'h0000

// Operating mode codes on op_mode
`define MPP_MODE_NONE 3'h0
`define MPP_MODE_PP 3'h1
`define MPP_MODE_PV 3'h2
`define MPP_MODE_JOG 3'h3
`define MPP_MODE_HOMING 3'h4

// Timing
`define MPP_CLK_HZ 32'h00989680
`define MPP_MS_PER_S 32'h000003e8
`define MPP_JERK_UNIT_MS 32'h00000001

`endif

// file: src/mpp_sat.v
// Registered signed saturation of a 32-bit value between two bounds
// Assumes lo is not above hi
`timescale 1ns/100ps
module mpp_sat (
  input wire mclk,
  input wire srst,
  input wire en,
  input wire signed [31:0] value,
  input wire signed [31:0] lo,
  input wire signed [31:0] hi,
  output reg signed [31:0] out_q
);
  reg signed [31:0] out_d;

  always @* begin
    out_d = value;
    if (en) begin
      if (value > hi) begin
        out_d = hi;
      end else if (value < lo) begin
        out_d = lo;
      end
    end
  end

  always @(posedge mclk) begin
    if (srst) begin
      out_q <= 32'h00000000;
    end else begin
      out_q <= out_d;
    end
  end
endmodule

// file: src/mpp_top.v
// Motion profile parameter set: parameter store, range checks, speed ceiling,
// target limits and jerk smoothing of the generator acceleration.
// Assumes one parameter access at a time from the fieldbus side, whole values.
//
// Overview of operation
// - Position target kept as signed 32-bit value in user units.
// - Position target limited by scaling bounds and enabled software limits.
// - Velocity target kept as signed 32-bit value in rpm.
// - Velocity target clamped internally to present speed ceiling.
// - Jerk time accepts 0,1,2,4,...,128 ms, default 0, limits acceleration change.
// - Smoothing at start, end of acceleration, start and end of deceleration.
// - Jerk limiting active in velocity, position, jog and homing modes.
// - Jerk time changed only while motion finished flag is one.
// - Ramp shape: -1 motor optimised, 0 linear.
// - Acceleration unsigned 32-bit, range 1 to 3000000, default 600.
// - Deceleration unsigned 32-bit, range 200 to 3000000, default 750.
// - 16-bit speed ceiling caps speeds in all profiled modes.
// - Ceiling applies in position, velocity, homing and jog modes.
// - Larger requested speeds limited to the ceiling automatically.
`timescale 1ns/100ps
`include "mpp_consts.vh"
module mpp_top #(
  parameter MS_CYCLES = `MPP_CLK_HZ / `MPP_MS_PER_S * `MPP_JERK_UNIT_MS
) (
  input wire mclk,
  input wire srst,
  input wire par_wr,
  input wire par_rd,
  input wire [15:0] par_addr,
  input wire [31:0] par_wdata,
  input wire [2:0] op_mode,
  input wire motion_end,
  input wire signed [31:0] pos_scale_min,
  input wire signed [31:0] pos_scale_max,
  input wire sw_limit_pos_en,
  input wire sw_limit_neg_en,
  input wire signed [31:0] sw_limit_pos,
  input wire signed [31:0] sw_limit_neg,
  input wire signed [31:0] vel_request,
  input wire signed [31:0] accel_demand,
  output reg par_ack_q,
  output reg par_err_q,
  output reg [31:0] par_rdata_q,
  output reg [15:0] speed_ceiling_q,
  output reg [31:0] profile_acceleration_q,
  output reg [31:0] profile_deceleration_q,
  output reg [15:0] jerk_filter_time_q,
  output reg [15:0] ramp_shape_select_q,
  output reg ramp_motor_opt_q,
  output reg [31:0] velocity_mode_target_speed_q,
  output reg [31:0] position_mode_target_q,
  output reg [15:0] motion_profile_shape_q,
  output wire signed [31:0] vel_limited_q,
  output wire signed [31:0] pos_limited_q,
  output wire signed [31:0] req_limited_q,
  output reg signed [31:0] accel_smooth_q,
  output reg profiled_mode_q
);

  // ==========================================================
  // Decoding helpers
  // ==========================================================
  function is_profiled;
    input [2:0] mode;
    begin
      is_profiled = (mode == `MPP_MODE_PP) || (mode == `MPP_MODE_PV) ||
                    (mode == `MPP_MODE_JOG) || (mode == `MPP_MODE_HOMING);
    end
  endfunction

  function [3:0] jerk_shift;
    input [15:0] ms;
    integer i;
    begin
      jerk_shift = 4'h0;
      for (i = 0; i < 8; i = i + 1) begin
        if (ms == (16'h0001 << i)) begin
          jerk_shift = i[3:0] + 4'h1;
        end
      end
    end
  endfunction

  function jerk_valid;
    input [15:0] ms;
    begin
      jerk_valid = (ms == 16'h0000) || (jerk_shift(ms) != 4'h0);
    end
  endfunction

  // ==========================================================
  // Position limits
  // ==========================================================
  reg signed [31:0] pos_lo;
  reg signed [31:0] pos_hi;

  always @* begin
    pos_lo = pos_scale_min;
    pos_hi = pos_scale_max;
    if (sw_limit_pos_en && (sw_limit_pos < pos_hi)) begin
      pos_hi = sw_limit_pos;
    end
    if (sw_limit_neg_en && (sw_limit_neg > pos_lo)) begin
      pos_lo = sw_limit_neg;
    end
  end

  // ==========================================================
  // Parameter write decode and range checks
  // ==========================================================
  wire [15:0] wlo;
  wire signed [31:0] wsig;
  reg hit;
  reg ok;

  assign wlo = par_wdata[15:0];
  assign wsig = par_wdata;

  always @* begin
    hit = 1'b1;
    ok = 1'b1;
    case (par_addr)
      `MPP_ADDR_SPEED_CEILING: begin
        ok = (par_wdata[31:16] == 16'h0000) && (wlo >= `MPP_SPEED_CEILING_MIN) &&
             (wlo <= `MPP_SPEED_CEILING_MAX);
      end
      `MPP_ADDR_PROFILE_ACC: begin
        ok = (par_wdata >= `MPP_ACC_MIN) && (par_wdata <= `MPP_ACCDEC_MAX);
      end
      `MPP_ADDR_PROFILE_DEC: begin
        ok = (par_wdata >= `MPP_DEC_MIN) && (par_wdata <= `MPP_ACCDEC_MAX);
      end
      `MPP_ADDR_JERK_TIME: begin
        ok = (par_wdata[31:16] == 16'h0000) && jerk_valid(wlo) && motion_end;
      end
      `MPP_ADDR_RAMP_SHAPE: begin
        ok = (wlo == `MPP_RAMP_MOTOR_OPT) || (wlo == `MPP_RAMP_LINEAR);
      end
      `MPP_ADDR_VEL_TARGET: begin
        ok = 1'b1;
      end
      `MPP_ADDR_POS_TARGET: begin
        ok = (wsig >= pos_lo) && (wsig <= pos_hi);
      end
      `MPP_ADDR_PROFILE_SHAPE: begin
        ok = (wlo == `MPP_PROFILE_LINEAR);
      end
      default: begin
        hit = 1'b0;
        ok = 1'b0;
      end
    endcase
  end

  wire wr_ok;
  assign wr_ok = par_wr && ok;

  // ==========================================================
  // Parameter store
  // ==========================================================
  always @(posedge mclk) begin
    if (srst) begin
      speed_ceiling_q <= `MPP_RST_SPEED_CEILING;
      profile_acceleration_q <= `MPP_RST_PROFILE_ACC;
      profile_deceleration_q <= `MPP_RST_PROFILE_DEC;
      jerk_filter_time_q <= `MPP_RST_JERK_TIME;
      ramp_shape_select_q <= `MPP_RST_RAMP_SHAPE;
      velocity_mode_target_speed_q <= `MPP_RST_VEL_TARGET;
      position_mode_target_q <= `MPP_RST_POS_TARGET;
      motion_profile_shape_q <= `MPP_RST_PROFILE_SHAPE;
    end else if (wr_ok) begin
      case (par_addr)
        `MPP_ADDR_SPEED_CEILING: begin
          speed_ceiling_q <= wlo;
        end
        `MPP_ADDR_PROFILE_ACC: begin
          profile_acceleration_q <= par_wdata;
        end
        `MPP_ADDR_PROFILE_DEC: begin
          profile_deceleration_q <= par_wdata;
        end
        `MPP_ADDR_JERK_TIME: begin
          jerk_filter_time_q <= wlo;
        end
        `MPP_ADDR_RAMP_SHAPE: begin
          ramp_shape_select_q <= wlo;
        end
        `MPP_ADDR_VEL_TARGET: begin
          velocity_mode_target_speed_q <= par_wdata;
        end
        `MPP_ADDR_POS_TARGET: begin
          position_mode_target_q <= par_wdata;
        end
        `MPP_ADDR_PROFILE_SHAPE: begin
          motion_profile_shape_q <= wlo;
        end
        default: begin
          speed_ceiling_q <= speed_ceiling_q;
        end
      endcase
    end
  end

  // ==========================================================
  // Parameter read and answer
  // ==========================================================
  reg [31:0] rd_mux;

  always @* begin
    case (par_addr)
      `MPP_ADDR_SPEED_CEILING: rd_mux = {16'h0000, speed_ceiling_q};
      `MPP_ADDR_PROFILE_ACC: rd_mux = profile_acceleration_q;
      `MPP_ADDR_PROFILE_DEC: rd_mux = profile_deceleration_q;
      `MPP_ADDR_JERK_TIME: rd_mux = {16'h0000, jerk_filter_time_q};
      `MPP_ADDR_RAMP_SHAPE: rd_mux = {{16{ramp_shape_select_q[15]}}, ramp_shape_select_q};
      `MPP_ADDR_VEL_TARGET: rd_mux = velocity_mode_target_speed_q;
      `MPP_ADDR_POS_TARGET: rd_mux = position_mode_target_q;
      `MPP_ADDR_PROFILE_SHAPE: rd_mux = {{16{motion_profile_shape_q[15]}}, motion_profile_shape_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge mclk) begin
    if (srst) begin
      par_ack_q <= 1'b0;
      par_err_q <= 1'b0;
      par_rdata_q <= 32'h00000000;
    end else begin
      par_ack_q <= par_wr || par_rd;
      par_err_q <= (par_wr && !ok) || (par_rd && !par_wr && !hit);
      if (par_rd && !par_wr) begin
        par_rdata_q <= rd_mux;
      end
    end
  end

  // ==========================================================
  // Mode flags and ramp shape
  // ==========================================================
  always @(posedge mclk) begin
    if (srst) begin
      profiled_mode_q <= 1'b0;
      ramp_motor_opt_q <= 1'b0;
    end else begin
      profiled_mode_q <= is_profiled(op_mode);
      ramp_motor_opt_q <= (ramp_shape_select_q == `MPP_RAMP_MOTOR_OPT);
    end
  end

  // ==========================================================
  // Speed ceiling and position limit
  // ==========================================================
  wire signed [31:0] ceil_hi;
  wire signed [31:0] ceil_lo;
  wire ceil_en;

  assign ceil_hi = {16'h0000, speed_ceiling_q};
  assign ceil_lo = -ceil_hi;
  assign ceil_en = is_profiled(op_mode);

  // Velocity target always held within the ceiling
  mpp_sat u_vel_sat (
    .mclk(mclk),
    .srst(srst),
    .en(1'b1),
    .value(velocity_mode_target_speed_q),
    .lo(ceil_lo),
    .hi(ceil_hi),
    .out_q(vel_limited_q)
  );

  // Speed requests of any profiled mode capped to the ceiling
  mpp_sat u_req_sat (
    .mclk(mclk),
    .srst(srst),
    .en(ceil_en),
    .value(vel_request),
    .lo(ceil_lo),
    .hi(ceil_hi),
    .out_q(req_limited_q)
  );

  // Position target kept inside the present bounds
  mpp_sat u_pos_sat (
    .mclk(mclk),
    .srst(srst),
    .en(1'b1),
    .value(position_mode_target_q),
    .lo(pos_lo),
    .hi(pos_hi),
    .out_q(pos_limited_q)
  );

  // ==========================================================
  // Jerk smoothing of generator acceleration
  // ==========================================================
  reg [31:0] ms_cnt_q;
  reg [31:0] ms_cnt_d;
  reg ms_tick_q;
  reg ms_tick_d;
  wire [3:0] jsh;
  wire jerk_on;
  wire signed [32:0] acc_diff;
  wire signed [32:0] acc_step_raw;
  reg signed [32:0] acc_step;
  reg signed [31:0] accel_smooth_d;

  assign jsh = jerk_shift(jerk_filter_time_q);
  assign jerk_on = (jsh != 4'h0) && is_profiled(op_mode);
  assign acc_diff = {accel_demand[31], accel_demand} - {accel_smooth_q[31], accel_smooth_q};
  assign acc_step_raw = acc_diff >>> jsh;

  always @* begin
    ms_cnt_d = ms_cnt_q + 32'h00000001;
    ms_tick_d = 1'b0;
    if (ms_cnt_q >= MS_CYCLES - 1) begin
      ms_cnt_d = 32'h00000000;
      ms_tick_d = 1'b1;
    end
  end

  always @* begin
    acc_step = acc_step_raw;
    if ((acc_step_raw == 33'h000000000) && (acc_diff != 33'h000000000)) begin
      acc_step = acc_diff;
    end
    accel_smooth_d = accel_smooth_q;
    if (!jerk_on) begin
      accel_smooth_d = accel_demand;
    end else if (ms_tick_q) begin
      // Each change of demand is eased per ms tick by the gap shifted by jsh; a rise smaller than 2^jsh is taken in one step
      accel_smooth_d = accel_smooth_q + acc_step[31:0];
    end
  end

  always @(posedge mclk) begin
    if (srst) begin
      ms_cnt_q <= 32'h00000000;
      ms_tick_q <= 1'b0;
      accel_smooth_q <= 32'h00000000;
    end else begin
      ms_cnt_q <= ms_cnt_d;
      ms_tick_q <= ms_tick_d;
      accel_smooth_q <= accel_smooth_d;
    end
  end

endmodule

// file: bench/mpp_monitor.sv
// Checker of the motion profile parameter ports
// Assumes a bind to mpp_top, single clock mclk, srst synchronous
`timescale 1ns/100ps
module mpp_monitor (
  input wire mclk,
  input wire srst,
  input wire par_wr,
  input wire par_rd,
  input wire [15:0] par_addr,
  input wire [31:0] par_wdata,
  input wire [2:0] op_mode,
  input wire motion_end,
  input wire signed [31:0] pos_scale_min,
  input wire signed [31:0] pos_scale_max,
  input wire sw_limit_pos_en,
  input wire sw_limit_neg_en,
  input wire signed [31:0] sw_limit_pos,
  input wire signed [31:0] vel_request,
  input wire signed [31:0] accel_demand,
  input wire par_ack_q,
  input wire par_err_q,
  input wire [31:0] par_rdata_q,
  input wire [15:0] speed_ceiling_q,
  input wire [31:0] profile_acceleration_q,
  input wire [15:0] jerk_filter_time_q,
  input wire [31:0] velocity_mode_target_speed_q,
  input wire [31:0] position_mode_target_q,
  input wire signed [31:0] vel_limited_q,
  input wire signed [31:0] pos_limited_q,
  input wire signed [31:0] req_limited_q,
  input wire signed [31:0] accel_smooth_q
);
  wire signed [31:0] ceil_s = {16'h0, speed_ceiling_q};
  // ==========
  // Properties
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  ack_follow_a: assert property ((par_wr || par_rd) |=> par_ack_q) else $error("ack missing");
  ack_idle_a: assert property (!(par_wr || par_rd) |=> !par_ack_q) else $error("stray ack");
  acc_range_a: assert property (par_wr && par_addr == 16'h0614 && (par_wdata == 32'h0 || par_wdata > 32'h2dc6c0)
    |=> par_err_q && $stable(profile_acceleration_q)) else $error("acc kept");
  jerk_moving_a: assert property (par_wr && par_addr == 16'h061a && !motion_end
    |=> par_err_q && $stable(jerk_filter_time_q)) else $error("jerk kept");
  vel_clamp_a: assert property ($signed(velocity_mode_target_speed_q) > ceil_s
    |=> vel_limited_q == $past(ceil_s)) else $error("vel clamp");
  req_clamp_a: assert property (op_mode >= 3'h1 && op_mode <= 3'h4 && vel_request < -ceil_s
    |=> req_limited_q == -$past(ceil_s)) else $error("req clamp");
  pos_clamp_a: assert property (sw_limit_pos_en && !sw_limit_neg_en && sw_limit_pos < pos_scale_max
    && pos_scale_min < sw_limit_pos && $signed(position_mode_target_q) > sw_limit_pos
    |=> pos_limited_q == $past(sw_limit_pos)) else $error("pos clamp");
  smooth_pass_a: assert property ((jerk_filter_time_q == 16'h0 || op_mode == 3'h0)
    |=> accel_smooth_q == $past(accel_demand)) else $error("accel pass");
  read_back_a: assert property (par_rd && !par_wr && par_addr == 16'h0614
    |=> par_rdata_q == $past(profile_acceleration_q)) else $error("read data");
endmodule

// file: bench/mpp_master.sv
// Fieldbus master model issuing parameter accesses
// Assumes the one-cycle request pulse and ack handshake of mpp_top
`timescale 1ns/100ps
`include "mpp_consts.vh"
module mpp_master (
  input wire mclk,
  input wire motion_end,
  input wire par_ack_q,
  input wire par_err_q,
  input wire [31:0] par_rdata_q,
  output reg par_wr = 1'b0,
  output reg par_rd = 1'b0,
  output reg [15:0] par_addr = 16'h0,
  output reg [31:0] par_wdata = 32'h0
);
  // ==========
  // Access task
  task xfer(input w, input [15:0] a, input [31:0] d, output e, output [31:0] q);
    integer n;
    begin
      repeat (50) if (w && a == `MPP_ADDR_JERK_TIME && !motion_end) @(posedge mclk);
      @(posedge mclk);
      par_wr <= w;
      par_rd <= !w;
      par_addr <= a;
      par_wdata <= d;
      @(posedge mclk);
      par_wr <= 1'b0;
      par_rd <= 1'b0;
      n = 0;
      @(posedge mclk);
      while (!par_ack_q && n < 8) begin
        @(posedge mclk);
        n = n + 1;
      end
      e = par_ack_q ? par_err_q : 1'bx;
      q = par_rdata_q;
      par_addr <= ~a;
      par_wdata <= ~d;
    end
  endtask
endmodule

// file: bench/motion_profile_parameters_bench.sv
// Testbench of the motion profile parameter set
// Assumes mpp_top, mpp_master and mpp_monitor are compiled first
`timescale 1ns/100ps
`include "mpp_consts.vh"
`define CHK(n, x, g) begin samples_checked = samples_checked + 1; if ((g) !== (x)) begin \
  failures = failures + 1; $display("mismatch %s exp %h got %h", n, x, g); end end
module motion_profile_parameters_bench;
  reg mclk = 1'b0;
  reg srst = 1'b1;
  reg [2:0] op_mode = 3'h0;
  reg motion_end = 1'b1;
  reg signed [31:0] pos_scale_min = 32'h80000000;
  reg signed [31:0] pos_scale_max = 32'h7fffffff;
  reg sw_limit_pos_en = 1'b0;
  reg sw_limit_neg_en = 1'b0;
  reg signed [31:0] sw_limit_pos = 32'h0;
  reg signed [31:0] sw_limit_neg = 32'h0;
  reg signed [31:0] vel_request = 32'h0;
  reg signed [31:0] accel_demand = 32'h0;
  wire par_wr, par_rd, par_ack_q, par_err_q;
  wire [15:0] par_addr;
  wire [31:0] par_wdata, par_rdata_q, profile_deceleration_q;
  wire [15:0] ramp_shape_select_q, motion_profile_shape_q;
  wire ramp_motor_opt_q, profiled_mode_q;
  wire signed [31:0] vel_limited_q, pos_limited_q, req_limited_q, accel_smooth_q;
  integer failures = 0;
  integer samples_checked = 0;
  integer cycles = 0;
  integer i;
  reg e;
  reg [31:0] q;
  mpp_top #(.MS_CYCLES(10)) u_mpp_top (.mclk, .srst, .par_wr, .par_rd, .par_addr, .par_wdata, .op_mode, .motion_end,
    .pos_scale_min, .pos_scale_max, .sw_limit_pos_en, .sw_limit_neg_en, .sw_limit_pos, .sw_limit_neg, .vel_request,
    .accel_demand, .par_ack_q, .par_err_q, .par_rdata_q, .speed_ceiling_q(), .profile_acceleration_q(),
    .profile_deceleration_q, .jerk_filter_time_q(), .ramp_shape_select_q, .ramp_motor_opt_q,
    .velocity_mode_target_speed_q(), .position_mode_target_q(), .motion_profile_shape_q, .vel_limited_q,
    .pos_limited_q, .req_limited_q, .accel_smooth_q, .profiled_mode_q);
  mpp_master u_mpp_master (.mclk, .motion_end, .par_ack_q, .par_err_q, .par_rdata_q, .par_wr, .par_rd, .par_addr,
    .par_wdata);
  // ==========
  // Clock, timeout and verdict
  initial forever #50 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles <= cycles + 1;
  end
  task summarize;
    begin
      $display("checked %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
        $display("bench passed");
      end else begin
        $display("bench failed");
      end
      $finish;
    end
  endtask
  task chk(input w, input [15:0] a, input [31:0] d, input x, input [31:0] r);
    begin
      if (w) begin
        u_mpp_master.xfer(1'h1, a, d, e, q);
        `CHK("write error", x, e)
      end
      u_mpp_master.xfer(1'h0, a, 32'h0, e, q);
      `CHK("read data", r, q)
    end
  endtask
  // ==========
  // Tests
  initial begin
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    fork
      begin
        chk(1'h0, `MPP_ADDR_SPEED_CEILING, 32'h0, 1'h0, 32'h3390);
        chk(1'h0, `MPP_ADDR_PROFILE_DEC, 32'h0, 1'h0, 32'h2ee);
        chk(1'h0, `MPP_ADDR_JERK_TIME, 32'h0, 1'h0, 32'h0);
        chk(1'h1, `MPP_ADDR_PROFILE_ACC, 32'h0, 1'h1, 32'h258);
        chk(1'h1, `MPP_ADDR_PROFILE_ACC, 32'h1, 1'h0, 32'h1);
        chk(1'h1, `MPP_ADDR_PROFILE_ACC, 32'h2dc6c1, 1'h1, 32'h1);
        chk(1'h1, `MPP_ADDR_PROFILE_ACC, 32'h2dc6c0, 1'h0, 32'h2dc6c0);
        chk(1'h1, `MPP_ADDR_PROFILE_DEC, 32'hc7, 1'h1, 32'h2ee);
        chk(1'h1, `MPP_ADDR_PROFILE_DEC, 32'hc8, 1'h0, 32'hc8);
        `CHK("decel", 32'hc8, profile_deceleration_q)
        for (i = 0; i < 8; i = i + 1) begin
          chk(1'h1, `MPP_ADDR_JERK_TIME, 32'h1 << i, 1'h0, 32'h1 << i);
        end
        chk(1'h1, `MPP_ADDR_JERK_TIME, 32'h3, 1'h1, 32'h80);
        chk(1'h1, `MPP_ADDR_JERK_TIME, 32'h100, 1'h1, 32'h80);
        chk(1'h1, `MPP_ADDR_RAMP_SHAPE, 32'hffff, 1'h0, 32'hffffffff);
        `CHK("ramp shape", 16'hffff, ramp_shape_select_q)
        `CHK("ramp opt", 1'h1, ramp_motor_opt_q)
        chk(1'h1, `MPP_ADDR_RAMP_SHAPE, 32'h1, 1'h1, 32'hffffffff);
        chk(1'h1, `MPP_ADDR_RAMP_SHAPE, 32'h0, 1'h0, 32'h0);
        `CHK("ramp opt", 1'h0, ramp_motor_opt_q)
        chk(1'h1, `MPP_ADDR_PROFILE_SHAPE, 32'h1, 1'h1, 32'h0);
        `CHK("profile shape", 16'h0, motion_profile_shape_q)
        chk(1'h1, `MPP_ADDR_SPEED_CEILING, 32'h3b, 1'h1, 32'h3390);
        chk(1'h1, `MPP_ADDR_SPEED_CEILING, 32'h3e8, 1'h0, 32'h3e8);
        u_mpp_master.xfer(1'h1, 16'h0700, 32'h0, e, q);
        `CHK("unmapped", 1'h1, e)
        u_mpp_master.xfer(1'h0, 16'h0700, 32'h0, e, q);
        `CHK("unmapped rd", 1'h1, e)
        `CHK("unmapped data", 32'h0, q)
        motion_end <= 1'b0;
        chk(1'h1, `MPP_ADDR_JERK_TIME, 32'h8, 1'h1, 32'h80);
        motion_end <= 1'b1;
        chk(1'h1, `MPP_ADDR_JERK_TIME, 32'h8, 1'h0, 32'h8);
        $display("test registers done");
        chk(1'h1, `MPP_ADDR_VEL_TARGET, 32'h1388, 1'h0, 32'h1388);
        `CHK("vel clamp", 32'h3e8, vel_limited_q)
        chk(1'h1, `MPP_ADDR_VEL_TARGET, 32'hffffec78, 1'h0, 32'hffffec78);
        `CHK("vel clamp", 32'hfffffc18, vel_limited_q)
        for (i = 1; i < 5; i = i + 1) begin
          op_mode <= i[2:0];
          vel_request <= 32'hfffff830;
          repeat (3) @(posedge mclk);
          `CHK("req clamp", 32'hfffffc18, req_limited_q)
          `CHK("profiled", 1'h1, profiled_mode_q)
        end
        vel_request <= 32'h7d0;
        repeat (3) @(posedge mclk);
        `CHK("req clamp", 32'h3e8, req_limited_q)
        op_mode <= 3'h0;
        repeat (3) @(posedge mclk);
        `CHK("req pass", 32'h7d0, req_limited_q)
        `CHK("profiled", 1'h0, profiled_mode_q)
        pos_scale_max <= 32'h64;
        chk(1'h1, `MPP_ADDR_POS_TARGET, 32'hc8, 1'h1, 32'h0);
        sw_limit_pos_en <= 1'b1;
        sw_limit_pos <= 32'h32;
        chk(1'h1, `MPP_ADDR_POS_TARGET, 32'h3c, 1'h1, 32'h0);
        chk(1'h1, `MPP_ADDR_POS_TARGET, 32'h28, 1'h0, 32'h28);
        sw_limit_pos <= 32'h1e;
        repeat (3) @(posedge mclk);
        `CHK("pos clamp", 32'h1e, pos_limited_q)
        $display("test limits done");
        accel_demand <= 32'h3e8;
        op_mode <= 3'h1;
        repeat (3) @(posedge mclk);
        `CHK("smooth start", 1'h1, accel_smooth_q < 32'sh3e8)
        repeat (1000) @(posedge mclk);
        `CHK("smooth end", 32'h3e8, accel_smooth_q)
        op_mode <= 3'h0;
        accel_demand <= 32'h1f4;
        repeat (2) @(posedge mclk);
        `CHK("smooth pass", 32'h1f4, accel_smooth_q)
        $display("test smoothing done");
      end
      begin
        while (cycles < 20000) @(posedge mclk);
        failures = failures + 1;
        $display("mismatch timeout exp %h got %h", 1'h0, 1'h1);
      end
    join_any
    summarize;
  end
endmodule
bind mpp_top mpp_monitor u_mpp_monitor (.mclk, .srst, .par_wr, .par_rd, .par_addr, .par_wdata, .op_mode, .motion_end,
  .pos_scale_min, .pos_scale_max, .sw_limit_pos_en, .sw_limit_neg_en, .sw_limit_pos, .vel_request, .accel_demand,
  .par_ack_q, .par_err_q, .par_rdata_q, .speed_ceiling_q, .profile_acceleration_q, .jerk_filter_time_q,
  .velocity_mode_target_speed_q, .position_mode_target_q, .vel_limited_q, .pos_limited_q, .req_limited_q,
  .accel_smooth_q);
